// >>> core/xpc_pkg.sv
// constants for the crosspoint switch host controller
// assumes a 25 MHz clock and an apb master issuing 32-bit accesses
package xpc_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_WH_NS = 20;
   localparam int T_WL_NS = 20;
   localparam int T_DS_NS = 20;
   localparam int T_DH_NS = 25;
   localparam int T_L_NS = 40;
   localparam int T_D_NS = 40;

   // least times round up, never below one cycle
   function automatic logic [3:0] xpc_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) c = 1;
      return 4'(c);
   endfunction

   localparam logic [3:0] WH_CYC = xpc_cycles(T_WH_NS);
   localparam logic [3:0] SETUP_CYC = xpc_cycles((T_DS_NS > T_WL_NS) ?
                                                 T_DS_NS : T_WL_NS);
   localparam logic [3:0] DH_CYC = xpc_cycles(T_DH_NS);
   localparam logic [3:0] L_CYC = xpc_cycles(T_L_NS);
   localparam logic [3:0] D_CYC = xpc_cycles(T_D_NS);

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_FRAME = 8'h08;
   localparam logic [7:0] REG_LATCH = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CHAIN = 8'h14;

   localparam int CTRL_SERIAL = 0;
   localparam int CTRL_EDGE = 1;
   localparam int CTRL_LIDLE = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_ERR = 1;
   localparam logic [2:0] CTRL_RESET = 3'h4;

   localparam logic [3:0] CODE_SER_MAX = 4'ha;
   localparam logic [3:0] CODE_SER_EN = 4'h9;
   localparam logic [4:0] FRAME_LAST = 5'h1f;

   typedef enum logic [2:0] {
      XPC_IDLE, XPC_SETUP, XPC_HIGH, XPC_HOLD, XPC_LDLY, XPC_LACT
   } xpc_state_e;
endpackage

// >>> core/xpc_host.sv
// host controller that drives the crosspoint switch control pins
// assumes apb from software; nibble line 1 is two-way, read in serial mode
`timescale 1ns/100ps
module xpc_host
   import xpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic interfaceSelect,
   output logic latchStyleSelect,
   output logic chipSelHigh,
   output logic chipSelLowN,
   output logic writeStrobe,
   output logic transferStrobe,
   output logic [2:0] outputSelectLines,
   output logic [3:0] commandNibbleOut,
   output logic commandNibbleOe,
   input wire logic commandNibbleIn
);
   xpc_state_e state;
   logic [2:0] ctrl;
   logic errFlag;
   logic [3:0] cnt;
   logic [4:0] bitCnt;
   logic [31:0] frame;
   logic [31:0] chain;
   logic serialRun;
   logic syncA, syncB, syncC, serIn;

   // any code above the serial range makes a frame illegal
   function automatic logic frame_bad(input logic [31:0] f);
      logic bad;
      bad = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (f[i*4 +: 4] > CODE_SER_MAX) bad = 1'b1;
      end
      return bad;
   endfunction

   logic access, busy, startOk, wrCtrl, wrCmd, wrFrame, wrLatch, wrStat;
   logic cmdBad, frameBad, mapped;
   assign access = psel & penable & ~pready;
   assign busy = (state != XPC_IDLE);
   assign wrCtrl = access & pwrite & (paddr == REG_CTRL);
   assign wrCmd = access & pwrite & (paddr == REG_CMD);
   assign wrFrame = access & pwrite & (paddr == REG_FRAME);
   assign wrLatch = access & pwrite & (paddr == REG_LATCH);
   assign wrStat = access & pwrite & (paddr == REG_STATUS);
   // parallel mode refuses the serial-only codes
   assign cmdBad = ctrl[CTRL_SERIAL] | (pwdata[6:3] == CODE_SER_EN) |
                   (pwdata[6:3] == CODE_SER_MAX);
   assign frameBad = ~ctrl[CTRL_SERIAL] | frame_bad(pwdata);
   assign mapped = (paddr == REG_CTRL) | (paddr == REG_CMD) |
                   (paddr == REG_FRAME) | (paddr == REG_LATCH) |
                   (paddr == REG_STATUS) | (paddr == REG_CHAIN);
   assign startOk = ~busy & ((wrCmd & ~cmdBad) | (wrFrame & ~frameBad) |
                             wrLatch);

   // apb answer one cycle into the access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= access;
         pslverr <= access & (~mapped |
                    (pwrite & (paddr == REG_CHAIN)) |
                    ((wrCmd | wrFrame | wrLatch | wrCtrl) & busy) |
                    (wrCmd & cmdBad) | (wrFrame & frameBad));
         prdata <= 32'h0;
         if (access & ~pwrite) begin
            unique case (paddr)
               REG_CTRL: prdata <= {29'h0, ctrl};
               REG_STATUS: prdata <= {30'h0, errFlag, busy};
               REG_CHAIN: prdata <= chain;
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
      end else if (ce && wrCtrl && !busy) begin
         ctrl <= pwdata[2:0];
      end
   end

   // hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         errFlag <= 1'b0;
      end else if (ce) begin
         if ((wrCmd & cmdBad) | (wrFrame & frameBad))
            errFlag <= 1'b1;
         else if (wrStat && pwdata[ST_ERR])
            errFlag <= 1'b0;
      end
   end

   // mode pins follow the control register
   always_ff @(posedge clk) begin
      if (rst) begin
         interfaceSelect <= 1'b0;
         latchStyleSelect <= 1'b0;
         commandNibbleOe <= 1'b1;
      end else if (ce) begin
         interfaceSelect <= ctrl[CTRL_SERIAL];
         latchStyleSelect <= ctrl[CTRL_EDGE];
         commandNibbleOe <= ~ctrl[CTRL_SERIAL];
      end
   end

   // serial chain output, three stages, taken once two agree
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         syncC <= 1'b0;
         serIn <= 1'b0;
      end else if (ce) begin
         syncA <= commandNibbleIn;
         syncB <= syncA;
         syncC <= syncB;
         if (syncB == syncC) serIn <= syncC;
      end
   end

   // strobe sequencer: setup, write high, hold, repeat for serial bits
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= XPC_IDLE;
         cnt <= 4'h0;
         bitCnt <= 5'h0;
         serialRun <= 1'b0;
         frame <= 32'h0;
         chain <= 32'h0;
         chipSelHigh <= 1'b0;
         chipSelLowN <= 1'b1;
         writeStrobe <= 1'b0;
         transferStrobe <= 1'b1;
         outputSelectLines <= 3'h0;
         commandNibbleOut <= 4'h0;
      end else if (ce) begin
         unique case (state)
            XPC_IDLE: begin
               transferStrobe <= ctrl[CTRL_LIDLE];
               cnt <= 4'h1;
               if (startOk && wrLatch) begin
                  state <= XPC_LDLY;
               end else if (startOk && wrCmd) begin
                  serialRun <= 1'b0;
                  outputSelectLines <= pwdata[2:0];
                  commandNibbleOut <= pwdata[6:3];
                  chipSelHigh <= 1'b1;
                  chipSelLowN <= 1'b0;
                  state <= XPC_SETUP;
               end else if (startOk && wrFrame) begin
                  serialRun <= 1'b1;
                  bitCnt <= 5'h0;
                  frame <= {pwdata[30:0], 1'b0};
                  commandNibbleOut <= {3'h0, pwdata[31]};
                  chipSelHigh <= 1'b1;
                  chipSelLowN <= 1'b0;
                  state <= XPC_SETUP;
               end
            end
            XPC_SETUP: begin
               cnt <= cnt + 4'h1;
               if (cnt >= SETUP_CYC) begin
                  writeStrobe <= 1'b1;
                  cnt <= 4'h1;
                  state <= XPC_HIGH;
               end
            end
            XPC_HIGH: begin
               cnt <= cnt + 4'h1;
               if (cnt >= WH_CYC) begin
                  writeStrobe <= 1'b0;
                  cnt <= 4'h1;
                  state <= XPC_HOLD;
               end
            end
            XPC_HOLD: begin
               cnt <= cnt + 4'h1;
               if (cnt >= DH_CYC) begin
                  cnt <= 4'h1;
                  if (serialRun) begin
                     chain <= {chain[30:0], serIn};
                     if (bitCnt == FRAME_LAST) begin
                        state <= XPC_IDLE;
                     end else begin
                        bitCnt <= bitCnt + 5'h1;
                        commandNibbleOut <= {3'h0, frame[31]};
                        frame <= {frame[30:0], 1'b0};
                        state <= XPC_SETUP;
                     end
                  end else begin
                     state <= XPC_IDLE;
                  end
                  if (!serialRun || bitCnt == FRAME_LAST) begin
                     chipSelHigh <= 1'b0;
                     chipSelLowN <= 1'b1;
                  end
               end
            end
            XPC_LDLY: begin
               cnt <= cnt + 4'h1;
               if (cnt >= D_CYC) begin
                  // pulse away from the idle level
                  transferStrobe <= ~ctrl[CTRL_LIDLE];
                  cnt <= 4'h1;
                  state <= XPC_LACT;
               end
            end
            XPC_LACT: begin
               cnt <= cnt + 4'h1;
               if (cnt >= L_CYC) begin
                  transferStrobe <= ctrl[CTRL_LIDLE];
                  state <= XPC_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// >>> testbench/xpc_checker.sv
// pin and apb timing checks for the crosspoint host
// assumes ce held high; bound into xpc_host below
`timescale 1ns/100ps
module xpc_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic interfaceSelect,
   input wire logic chipSelHigh,
   input wire logic chipSelLowN,
   input wire logic writeStrobe,
   input wire logic [2:0] outputSelectLines,
   input wire logic [3:0] commandNibbleOut,
   input wire logic commandNibbleOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_sel;
      chipSelHigh && !chipSelLowN;
   endsequence
   sequence s_pulse;
      writeStrobe ##1 !writeStrobe;
   endsequence
   a_strobe_cs: assert property ($rose(writeStrobe) |-> s_sel)
      else $error("strobe without chip select");
   a_cs_hold: assert property ($fell(writeStrobe) |-> s_sel)
      else $error("chip select dropped early");
   a_strobe_width: assert property ($rose(writeStrobe) |-> s_pulse)
      else $error("strobe width wrong");
   a_data_setup: assert property ($rose(writeStrobe) |->
      $stable(outputSelectLines) && $stable(commandNibbleOut))
      else $error("data moved at strobe rise");
   a_data_hold: assert property ($fell(writeStrobe) |->
      $stable(outputSelectLines) && $stable(commandNibbleOut))
      else $error("data moved at strobe fall");
   a_ser_release: assert property (
      writeStrobe && interfaceSelect |-> !commandNibbleOe)
      else $error("chain line driven in serial mode");
   a_mode_steady: assert property (
      writeStrobe |-> $stable(interfaceSelect))
      else $error("mode changed during strobe");
   a_cs_pair: assert property (chipSelHigh |-> !chipSelLowN)
      else $error("chip selects disagree");
   a_apb_wait: assert property (psel && penable && !pready && ce |=> pready)
      else $error("apb answer late");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
endmodule

bind xpc_host xpc_checker xpc_checker_inst (.clk, .rst, .ce, .psel,
   .penable, .pready, .interfaceSelect, .chipSelHigh, .chipSelLowN,
   .writeStrobe, .outputSelectLines, .commandNibbleOut, .commandNibbleOe);

// >>> testbench/xpc_dev_model.sv
// behavioural model of the switch control logic at its pins
// assumes strobes from the host; no clock, strobe edges drive it
`timescale 1ns/100ps
module xpc_dev_model (
   input wire logic interfaceSelect,
   input wire logic latchStyleSelect,
   input wire logic chipSelHigh,
   input wire logic chipSelLowN,
   input wire logic writeStrobe,
   input wire logic transferStrobe,
   input wire logic [2:0] outputSelectLines,
   input wire logic [3:0] commandNibbleOut,
   output logic chainOut,
   output logic [31:0] masterBits,
   output logic [31:0] slaveBits,
   output logic [7:0] outEnable
);
   logic [3:0] c;
   logic [2:0] a;
   initial begin
      masterBits = 32'h0;
      slaveBits = 32'h0;
      outEnable = 8'h00;
   end
   // serial codes act on the enables only when slaves load
   task automatic load;
      for (int i = 0; i < 8; i++) begin
         c = masterBits[31-4*i -: 4];
         if (interfaceSelect && c == 4'h9) begin
            outEnable[i] = 1'b1;
         end
         if (interfaceSelect && c == 4'ha) begin
            outEnable[i] = 1'b0;
         end
      end
      slaveBits = masterBits;
   endtask
   always @(posedge transferStrobe) if (latchStyleSelect) load();
   always @(masterBits or transferStrobe or latchStyleSelect) begin
      if (latchStyleSelect === 1'b0 && transferStrobe === 1'b0) load();
   end
   always @(posedge writeStrobe) begin
      a = outputSelectLines;
      if (chipSelHigh && !chipSelLowN) begin
         if (interfaceSelect) begin
            masterBits = {masterBits[30:0], commandNibbleOut[0]};
         end else if (commandNibbleOut <= 4'h8) begin
            masterBits[31-4*a -: 4] = commandNibbleOut;
         end else begin
            case (commandNibbleOut)
               4'hb: outEnable[a] = 1'b0;
               4'hc: outEnable[a] = 1'b1;
               4'hd: outEnable = 8'h00;
               4'he: outEnable = 8'hff;
               4'hf: if (transferStrobe) load();
               default: ;
            endcase
         end
      end
   end
   // off serial mode the line shows junk, not the last bit
   assign chainOut = interfaceSelect ? masterBits[31] : ~commandNibbleOut[1];
endmodule

// >>> testbench/testbench.sv
// self-checking bench: apb scenarios against the switch model
// assumes busy in status bit 0, error in bit 1; apb waits end on watchdog
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("Error at %0t got %h exp %h", $time, g, e); end end
module testbench;
   import xpc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00, outEnable;
   logic [31:0] pwdata = 32'h0, prdata, rd, masterBits, slaveBits;
   logic interfaceSelect, latchStyleSelect, chipSelHigh, chipSelLowN;
   logic writeStrobe, transferStrobe, commandNibbleOe, chainOut, nibIn;
   logic [2:0] outputSelectLines;
   logic [3:0] commandNibbleOut;
   int fail_count = 0, checks_done = 0;
   always #20 clk = ~clk;
   assign nibIn = commandNibbleOe ? commandNibbleOut[1] : chainOut;
   xpc_host xpc_host_inst (.clk, .rst, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .interfaceSelect,
      .latchStyleSelect, .chipSelHigh, .chipSelLowN, .writeStrobe,
      .transferStrobe, .outputSelectLines, .commandNibbleOut,
      .commandNibbleOe, .commandNibbleIn(nibIn));
   xpc_dev_model xpc_dev_model_inst (.interfaceSelect, .latchStyleSelect,
      .chipSelHigh, .chipSelLowN, .writeStrobe, .transferStrobe,
      .outputSelectLines, .commandNibbleOut, .chainOut, .masterBits,
      .slaveBits, .outEnable);
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request held until the edge that sees pready; only the watchdog ends it
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      `CHK(pready, 1'b1)
      `CHK(pslverr, e)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wt;
      do begin
         apb(0, REG_STATUS, 0, 0);
      end while (rd[ST_BUSY] !== 1'b0);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d, 0);
      wt();
   endtask
   task cmd(input logic [3:0] c, input logic [2:0] a);
      wr(REG_CMD, {25'h0, c, a});
   endtask
   task close_out;
      $display("fail_count %0d checks_done %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task t_reset;
      `CHK(outEnable, 8'h00)
      `CHK(slaveBits, 32'h0)
      apb(0, REG_CTRL, 0, 0);
      `CHK(rd, 32'h4)
      apb(0, 8'h40, 0, 1);
   endtask
   task t_parallel;
      wr(REG_CTRL, 32'h6);
      cmd(4'h5, 3'h3);
      `CHK(masterBits, 32'h0005_0000)
      `CHK(slaveBits, 32'h0)
      wr(REG_LATCH, 0);
      `CHK(slaveBits, 32'h0005_0000)
      cmd(4'hc, 3'h3);
      `CHK(outEnable, 8'h08)
      cmd(4'he, 3'h1);
      `CHK(outEnable, 8'hff)
      cmd(4'hb, 3'h3);
      `CHK(outEnable, 8'hf7)
      cmd(4'hd, 3'h6);
      `CHK(outEnable, 8'h00)
      cmd(4'h8, 3'h2);
      `CHK(masterBits, 32'h0085_0000)
      cmd(4'hf, 3'h0);
      `CHK(slaveBits, 32'h0085_0000)
      wr(REG_CTRL, 32'h2);
      cmd(4'h4, 3'h0);
      cmd(4'hf, 3'h0);
      `CHK(slaveBits, 32'h0085_0000)
      for (int i = 0; i < 8; i++) cmd(4'(i), 3'(7 - i));
      `CHK(masterBits, 32'h7654_3210)
      `CHK(outEnable, 8'h00)
   endtask
   task t_refuse;
      apb(1, REG_CMD, {25'h0, 4'h9, 3'h0}, 1);
      apb(1, REG_CMD, {25'h0, 4'ha, 3'h0}, 1);
      apb(1, REG_FRAME, 32'h0, 1);
      `CHK(masterBits, 32'h7654_3210)
      apb(0, REG_STATUS, 0, 0);
      `CHK(rd[ST_ERR], 1'b1)
      apb(1, REG_STATUS, 32'h2, 0);
      apb(0, REG_STATUS, 0, 0);
      `CHK(rd[ST_ERR], 1'b0)
      apb(1, REG_CHAIN, 0, 1);
   endtask
   // chain readback after a frame is the master content shifted out
   task t_serial;
      wr(REG_CTRL, 32'h7);
      apb(1, REG_FRAME, 32'hb000_0000, 1);
      wr(REG_FRAME, 32'h9999_9999);
      `CHK(masterBits, 32'h9999_9999)
      apb(0, REG_CHAIN, 0, 0);
      `CHK(rd, 32'h7654_3210)
      wr(REG_LATCH, 0);
      `CHK(outEnable, 8'hff)
      wr(REG_CTRL, 32'h5);
      apb(1, REG_FRAME, 32'h0123_456a, 0);
      // refused: sequence still running, and serial mode anyway
      apb(1, REG_CMD, {25'h0, 4'h1, 3'h0}, 1);
      wt();
      `CHK(slaveBits, 32'h9999_9999)
      `CHK(masterBits, 32'h0123_456a)
      apb(0, REG_CHAIN, 0, 0);
      `CHK(rd, 32'h9999_9999)
      wr(REG_LATCH, 0);
      `CHK(slaveBits, 32'h0123_456a)
      `CHK(outEnable, 8'h7f)
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_parallel();
      t_refuse();
      t_serial();
      close_out();
   end
   initial begin
      #2000000;
      fail_count++;
      close_out();
   end
endmodule
